// file: hdl/gew_defines.svh
/*
 Constants of the guest-entry sequencer: register offsets, control-block layout,
 field positions, exit codes and address sizes. Assumes 64-bit memory words and a
 32-bit plain register port.
*/
`ifndef GEW_DEFINES_SVH
`define GEW_DEFINES_SVH
`define GEW_RA_HSAVE_LO 8'h00
`define GEW_RA_HSAVE_HI 8'h04
`define GEW_RA_STATUS 8'h08
`define GEW_RA_CTRL 8'h0C
`define GEW_RA_TAGS 8'h10
`define GEW_TAG_COUNT 32'h0000_0040
`define GEW_HSAVE_N 4'hE
`define GEW_GLOAD_N 5'h1C
`define GEW_PAGE_DIR_POINTER_ENTRY_N 3'h4
`define GEW_GI_CTRL 5'h00
`define GEW_GI_ADDRESS_SPACE_TAG 5'h01
`define GEW_GI_TSC 5'h02
`define GEW_GI_CSATTR 5'h03
`define GEW_GI_CSLIM 5'h04
`define GEW_GI_RIP 5'h06
`define GEW_GI_RFLAGS 5'h07
`define GEW_GI_SSATTR 5'h09
`define GEW_GI_CR0 5'h0E
`define GEW_GI_CR3 5'h10
`define GEW_GI_CR4 5'h11
`define GEW_GI_EXTENDED_FEATURES_REG 5'h12
`define GEW_GI_DR6 5'h18
`define GEW_GI_DR7 5'h19
`define GEW_GI_CPL 5'h1B
`define GEW_CTRL_ENTRY_ICPT 32
`define GEW_CTRL_NESTED 33
`define GEW_CR0_PE 0
`define GEW_CR0_NW 29
`define GEW_CR0_CD 30
`define GEW_CR0_PG 31
`define GEW_CR4_PAE 5
`define GEW_EXTENDED_FEATURES_REG_LME 8
`define GEW_EXTENDED_FEATURES_REG_LMA 10
`define GEW_EXTENDED_FEATURES_REG_VEN 12
`define GEW_FL_VM 17
`define GEW_PAGE_DIR_POINTER_ENTRY_RSVD 64'h0000_0000_0000_01E6
`define GEW_EXIT_INVALID 16'hFFFF
`define GEW_AS_16 2'h0
`define GEW_AS_32 2'h1
`endif

// file: hdl/gew_pkg.sv
/*
 Types of the guest-entry sequencer. Assumes gew_defines.svh for numbers.
*/
package gew_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SAVE = 3'h1,
    ST_LOAD = 3'h2,
    ST_CHECK = 3'h3,
    ST_PAGE_DIR_POINTER_ENTRY = 3'h4,
    ST_GUEST = 3'h5,
    ST_EXIT = 3'h6
  } gew_state_e;
  typedef struct packed {
    logic req;
    logic we;
    logic [63:0] addr;
    logic [63:0] wdata;
  } gew_mem_req_s;
  typedef struct packed {
    logic cs_d;
    logic cs_l;
    logic cs_r;
    logic ss_b;
    logic ss_e;
    logic ss_w;
    logic ss_code;
    logic ss_present;
  } gew_seg_view_s;
endpackage

// file: hdl/gew_guest_entry.sv
/*
 Guest-entry sequencer: checks, host save, guest load, consistency and
 page-directory-pointer checks, guest run and exit bookkeeping.
 Assumes memory and core-side signals share SYS_CLK, a memory that holds
 ACK high for one cycle per request, and HOST_VAL valid for HOST_SEL in-cycle.
*/
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "gew_defines.svh"
module gew_guest_entry (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic ENTRY_REQ,
  input wire logic [1:0] CUR_CPL,
  input wire logic PROT_MODE,
  input wire logic VIRT_EN,
  input wire logic [1:0] ADDR_SIZE,
  input wire logic [63:0] ACC_REG,
  output logic [3:0] HOST_SEL,
  input wire logic [63:0] HOST_VAL,
  output gew_pkg::gew_mem_req_s MEM_OUT,
  input wire logic MEM_ACK,
  input wire logic [63:0] MEM_RDATA,
  output logic GST_WE,
  output logic [4:0] GST_IDX,
  output logic [63:0] GST_DATA,
  output logic FAULT_GP,
  output logic FAULT_UD,
  output logic [15:0] FAULT_ERR,
  output logic GP_IN_GUEST,
  output logic IN_GUEST,
  output logic GLOBAL_IRQ_GATE_FLAG,
  output logic [1:0] GUEST_CPL,
  output gew_pkg::gew_seg_view_s SEG_VIEW,
  output logic [31:0] INTERCEPT_VEC,
  output logic [31:0] ACTIVE_TAG,
  input wire logic INTERCEPT_HIT,
  input wire logic [15:0] INTERCEPT_CODE,
  output logic HOST_RESUME,
  output logic [15:0] EXIT_CODE,
  input wire logic TSC_RD,
  input wire logic [63:0] TSC_VAL,
  output logic [63:0] TSC_OUT,
  output logic TSC_OUT_VLD
);
  gew_pkg::gew_state_e st_ff;
  gew_pkg::gew_state_e nxt_st;
  logic [63:0] hsave_ff;
  logic [63:0] blk_ff;
  logic [4:0] idx_ff;
  logic [63:0] ctrl_ff, tsc_ff, cr0_ff, cr3_ff, cr4_ff, extended_features_reg_ff;
  logic [63:0] rip_ff, fl_ff, dr6_ff, dr7_ff, cslim_ff;
  logic [11:0] csattr_ff, ssattr_ff;
  logic [1:0] cplf_ff;
  logic page_dir_pointer_entry_bad_ff;
  logic exit_inval_ff;
  logic [63:0] acc_cut;
  logic xfer_done;
  logic last_item;
  logic long64;
  logic pae_legacy;
  logic bad_state;
  logic rip_bad;
  logic sw_gif_clr, sw_gif_set;

  // only the part picked by the address size counts; low 12 bits dropped
  always_comb begin
    case (ADDR_SIZE)
      `GEW_AS_16: acc_cut = {48'h0000_0000_0000, ACC_REG[15:0]};
      `GEW_AS_32: acc_cut = {32'h0000_0000, ACC_REG[31:0]};
      default: acc_cut = ACC_REG;
    endcase
  end

  assign xfer_done = MEM_OUT.req && MEM_ACK;
  assign long64 = extended_features_reg_ff[`GEW_EXTENDED_FEATURES_REG_LMA] && csattr_ff[9];
  assign pae_legacy = cr4_ff[`GEW_CR4_PAE] && cr0_ff[`GEW_CR0_PG] && !extended_features_reg_ff[`GEW_EXTENDED_FEATURES_REG_LME];
  assign rip_bad = long64 ? (rip_ff[63:47] != {17{rip_ff[47]}}) : (rip_ff > cslim_ff);

  always_comb begin
    case (st_ff)
      gew_pkg::ST_SAVE: last_item = idx_ff[3:0] == `GEW_HSAVE_N - 4'h1;
      gew_pkg::ST_LOAD: last_item = idx_ff == `GEW_GLOAD_N - 5'h01;
      default: last_item = idx_ff[2:0] == `GEW_PAGE_DIR_POINTER_ENTRY_N - 3'h1;
    endcase
  end

  // consistency of the loaded guest; an odd instruction pointer is not part of it
  always_comb begin
    bad_state = 1'b0;
    if (!extended_features_reg_ff[`GEW_EXTENDED_FEATURES_REG_VEN]) bad_state = 1'b1;
    if (!cr0_ff[`GEW_CR0_CD] && cr0_ff[`GEW_CR0_NW]) bad_state = 1'b1;
    if (cr0_ff[63:32] != 32'h0000_0000) bad_state = 1'b1;
    if (dr6_ff[63:32] != 32'h0000_0000) bad_state = 1'b1;
    if (dr7_ff[63:32] != 32'h0000_0000) bad_state = 1'b1;
    if (extended_features_reg_ff[`GEW_EXTENDED_FEATURES_REG_LME] && cr0_ff[`GEW_CR0_PG]) begin
      if (!cr4_ff[`GEW_CR4_PAE]) bad_state = 1'b1;
      if (!cr0_ff[`GEW_CR0_PE]) bad_state = 1'b1;
      if (cr4_ff[`GEW_CR4_PAE] && csattr_ff[9] && csattr_ff[10]) bad_state = 1'b1;
    end
    if (!ctrl_ff[`GEW_CTRL_ENTRY_ICPT]) bad_state = 1'b1;
    if (ACTIVE_TAG == 32'h0000_0000) bad_state = 1'b1;
  end

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      gew_pkg::ST_IDLE:
        if (ENTRY_REQ && PROT_MODE && VIRT_EN && CUR_CPL == 2'h0) nxt_st = gew_pkg::ST_SAVE;
      gew_pkg::ST_SAVE:
        if (xfer_done && last_item) nxt_st = gew_pkg::ST_LOAD;
      gew_pkg::ST_LOAD:
        if (xfer_done && last_item) nxt_st = gew_pkg::ST_CHECK;
      gew_pkg::ST_CHECK: begin
        if (bad_state) nxt_st = gew_pkg::ST_EXIT;
        else if (pae_legacy && !ctrl_ff[`GEW_CTRL_NESTED]) nxt_st = gew_pkg::ST_PAGE_DIR_POINTER_ENTRY;
        else nxt_st = gew_pkg::ST_GUEST;
      end
      gew_pkg::ST_PAGE_DIR_POINTER_ENTRY:
        if (xfer_done && last_item) begin
          if (page_dir_pointer_entry_bad_ff || (MEM_RDATA[0] && (MEM_RDATA & `GEW_PAGE_DIR_POINTER_ENTRY_RSVD) != 64'h0000_0000_0000_0000))
            nxt_st = gew_pkg::ST_EXIT;
          else
            nxt_st = gew_pkg::ST_GUEST;
        end
      gew_pkg::ST_GUEST:
        if (INTERCEPT_HIT) nxt_st = gew_pkg::ST_EXIT;
      gew_pkg::ST_EXIT: nxt_st = gew_pkg::ST_IDLE;
      default: nxt_st = gew_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) st_ff <= gew_pkg::ST_IDLE;
    else st_ff <= nxt_st;
  end

  // faults are checked in the idle state only; undefined opcode wins since cpl means nothing outside protected mode
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      FAULT_GP <= 1'b0;
      FAULT_UD <= 1'b0;
      FAULT_ERR <= 16'h0000;
    end else begin
      FAULT_UD <= st_ff == gew_pkg::ST_IDLE && ENTRY_REQ && (!PROT_MODE || !VIRT_EN);
      FAULT_GP <= st_ff == gew_pkg::ST_IDLE && ENTRY_REQ && PROT_MODE && VIRT_EN
        && CUR_CPL != 2'h0;
      FAULT_ERR <= 16'h0000;
    end
  end

  // one word per request; request stays up until the memory acks it
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      MEM_OUT <= '0;
      idx_ff <= 5'h00;
      blk_ff <= 64'h0000_0000_0000_0000;
      page_dir_pointer_entry_bad_ff <= 1'b0;
    end else begin
      if (st_ff == gew_pkg::ST_IDLE && nxt_st == gew_pkg::ST_SAVE) begin
        blk_ff <= {acc_cut[63:12], 12'h000};
        idx_ff <= 5'h00;
      end
      if (st_ff == gew_pkg::ST_CHECK) begin
        idx_ff <= 5'h00;
        page_dir_pointer_entry_bad_ff <= 1'b0;
      end
      if (xfer_done) begin
        MEM_OUT.req <= 1'b0;
        idx_ff <= last_item ? 5'h00 : idx_ff + 5'h01;
        if (st_ff == gew_pkg::ST_PAGE_DIR_POINTER_ENTRY && MEM_RDATA[0]
            && (MEM_RDATA & `GEW_PAGE_DIR_POINTER_ENTRY_RSVD) != 64'h0000_0000_0000_0000)
          page_dir_pointer_entry_bad_ff <= 1'b1;
      end else if (!MEM_OUT.req) begin
        case (st_ff)
          gew_pkg::ST_SAVE: begin
            // the save list holds no local descriptor table entry
            MEM_OUT.req <= 1'b1;
            MEM_OUT.we <= 1'b1;
            MEM_OUT.addr <= hsave_ff + {57'h0, idx_ff[3:0], 3'h0};
            MEM_OUT.wdata <= HOST_VAL;
          end
          gew_pkg::ST_LOAD: begin
            MEM_OUT.req <= 1'b1;
            MEM_OUT.we <= 1'b0;
            MEM_OUT.addr <= blk_ff + {56'h0, idx_ff, 3'h0};
          end
          gew_pkg::ST_PAGE_DIR_POINTER_ENTRY: begin
            MEM_OUT.req <= 1'b1;
            MEM_OUT.we <= 1'b0;
            MEM_OUT.addr <= {32'h0000_0000, cr3_ff[31:5], 5'h00} + {58'h0, idx_ff[2:0], 3'h0};
          end
          default: MEM_OUT.req <= 1'b0;
        endcase
      end
    end
  end

  assign HOST_SEL = idx_ff[3:0];

  // every loaded word is passed to the core; the few the checks need are kept here
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      GST_WE <= 1'b0;
      GST_IDX <= 5'h00;
      GST_DATA <= 64'h0000_0000_0000_0000;
      ctrl_ff <= 64'h0000_0000_0000_0000;
      cr0_ff <= 64'h0000_0000_0000_0000;
      cr3_ff <= 64'h0000_0000_0000_0000;
      cr4_ff <= 64'h0000_0000_0000_0000;
      extended_features_reg_ff <= 64'h0000_0000_0000_0000;
      rip_ff <= 64'h0000_0000_0000_0000;
      fl_ff <= 64'h0000_0000_0000_0000;
      dr6_ff <= 64'h0000_0000_0000_0000;
      dr7_ff <= 64'h0000_0000_0000_0000;
      cslim_ff <= 64'h0000_0000_0000_0000;
      csattr_ff <= 12'h000;
      ssattr_ff <= 12'h000;
      cplf_ff <= 2'h0;
    end else begin
      GST_WE <= st_ff == gew_pkg::ST_LOAD && xfer_done;
      if (st_ff == gew_pkg::ST_LOAD && xfer_done) begin
        GST_IDX <= idx_ff;
        GST_DATA <= MEM_RDATA;
        // paging registers are taken over with no flush request raised
        case (idx_ff)
          `GEW_GI_CTRL: ctrl_ff <= MEM_RDATA;
          `GEW_GI_CSATTR: csattr_ff <= MEM_RDATA[27:16];
          `GEW_GI_CSLIM: cslim_ff <= {32'h0000_0000, MEM_RDATA[31:0]};
          `GEW_GI_RIP: rip_ff <= MEM_RDATA;
          `GEW_GI_RFLAGS: fl_ff <= MEM_RDATA;
          `GEW_GI_SSATTR: ssattr_ff <= MEM_RDATA[27:16];
          `GEW_GI_CR0: cr0_ff <= MEM_RDATA;
          `GEW_GI_CR3: cr3_ff <= MEM_RDATA;
          `GEW_GI_CR4: cr4_ff <= MEM_RDATA;
          `GEW_GI_EXTENDED_FEATURES_REG: extended_features_reg_ff <= MEM_RDATA;
          `GEW_GI_DR6: dr6_ff <= MEM_RDATA;
          `GEW_GI_DR7: dr7_ff <= MEM_RDATA;
          `GEW_GI_CPL: cplf_ff <= MEM_RDATA[1:0];
          default: cplf_ff <= cplf_ff;
        endcase
      end
    end
  end

  // control fields live from the guest load until exit; exit wipes them
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      INTERCEPT_VEC <= 32'h0000_0000;
      ACTIVE_TAG <= 32'h0000_0000;
      tsc_ff <= 64'h0000_0000_0000_0000;
    end else if (st_ff == gew_pkg::ST_EXIT) begin
      INTERCEPT_VEC <= 32'h0000_0000;
      ACTIVE_TAG <= 32'h0000_0000;
      tsc_ff <= 64'h0000_0000_0000_0000;
    end else if (st_ff == gew_pkg::ST_LOAD && xfer_done) begin
      if (idx_ff == `GEW_GI_CTRL) INTERCEPT_VEC <= MEM_RDATA[31:0];
      if (idx_ff == `GEW_GI_ADDRESS_SPACE_TAG) ACTIVE_TAG <= MEM_RDATA[31:0];
      if (idx_ff == `GEW_GI_TSC) tsc_ff <= MEM_RDATA;
    end
  end

  // guest timestamp reads see the offset, host reads see zero offset
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      TSC_OUT <= 64'h0000_0000_0000_0000;
      TSC_OUT_VLD <= 1'b0;
    end else begin
      TSC_OUT_VLD <= TSC_RD;
      if (TSC_RD) TSC_OUT <= TSC_VAL + tsc_ff;
    end
  end

  // guest view is settled once checks pass
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      IN_GUEST <= 1'b0;
      GUEST_CPL <= 2'h0;
      SEG_VIEW <= '0;
      GP_IN_GUEST <= 1'b0;
    end else begin
      GP_IN_GUEST <= 1'b0;
      if (st_ff != gew_pkg::ST_GUEST && nxt_st == gew_pkg::ST_GUEST) begin
        IN_GUEST <= 1'b1;
        GP_IN_GUEST <= rip_bad;
        if (!cr0_ff[`GEW_CR0_PE]) GUEST_CPL <= 2'h0;
        else if (fl_ff[`GEW_FL_VM]) GUEST_CPL <= 2'h3;
        else GUEST_CPL <= cplf_ff;
        // only these attribute bits are looked at
        SEG_VIEW.cs_d <= csattr_ff[10];
        SEG_VIEW.cs_l <= csattr_ff[9];
        SEG_VIEW.cs_r <= csattr_ff[1];
        SEG_VIEW.ss_b <= ssattr_ff[10];
        SEG_VIEW.ss_e <= ssattr_ff[2];
        SEG_VIEW.ss_w <= ssattr_ff[1];
        SEG_VIEW.ss_code <= ssattr_ff[3];
        // clear present marks a null stack, except in 64-bit mode
        SEG_VIEW.ss_present <= long64 | ssattr_ff[7];
      end else if (st_ff == gew_pkg::ST_EXIT) begin
        IN_GUEST <= 1'b0;
        GUEST_CPL <= 2'h0;
      end
    end
  end

  // exit: code and resume pulse; host resumes after the entry instruction
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      HOST_RESUME <= 1'b0;
      EXIT_CODE <= 16'h0000;
      exit_inval_ff <= 1'b0;
    end else begin
      HOST_RESUME <= st_ff == gew_pkg::ST_EXIT;
      if (st_ff != gew_pkg::ST_GUEST && nxt_st == gew_pkg::ST_EXIT) exit_inval_ff <= 1'b1;
      else if (st_ff == gew_pkg::ST_GUEST) exit_inval_ff <= 1'b0;
      if (st_ff == gew_pkg::ST_EXIT)
        EXIT_CODE <= exit_inval_ff ? `GEW_EXIT_INVALID : INTERCEPT_CODE;
    end
  end

  assign sw_gif_clr = WR && ADDR == `GEW_RA_CTRL && WDATA[0];
  assign sw_gif_set = WR && ADDR == `GEW_RA_CTRL && WDATA[1];

  // hardware set beats any clear in the same cycle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) GLOBAL_IRQ_GATE_FLAG <= 1'b1;
    else if (st_ff != gew_pkg::ST_GUEST && nxt_st == gew_pkg::ST_GUEST) GLOBAL_IRQ_GATE_FLAG <= 1'b1;
    else if (st_ff == gew_pkg::ST_EXIT) GLOBAL_IRQ_GATE_FLAG <= 1'b0;
    else if (sw_gif_clr) GLOBAL_IRQ_GATE_FLAG <= 1'b0;
    else if (sw_gif_set) GLOBAL_IRQ_GATE_FLAG <= 1'b1;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) hsave_ff <= 64'h0000_0000_0000_0000;
    else if (WR && ADDR == `GEW_RA_HSAVE_LO) hsave_ff[31:0] <= {WDATA[31:12], 12'h000};
    else if (WR && ADDR == `GEW_RA_HSAVE_HI) hsave_ff[63:32] <= WDATA;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) RDATA <= 32'h0000_0000;
    else if (RD) begin
      case (ADDR)
        `GEW_RA_HSAVE_LO: RDATA <= hsave_ff[31:0];
        `GEW_RA_HSAVE_HI: RDATA <= hsave_ff[63:32];
        `GEW_RA_STATUS: RDATA <= {EXIT_CODE, 8'h00, 1'b0, st_ff, 2'h0, IN_GUEST, GLOBAL_IRQ_GATE_FLAG};
        `GEW_RA_TAGS: RDATA <= `GEW_TAG_COUNT;
        default: RDATA <= 32'h0000_0000;
      endcase
    end else RDATA <= 32'h0000_0000;
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  property p_gp;
    st_ff == gew_pkg::ST_IDLE && ENTRY_REQ && PROT_MODE && VIRT_EN && CUR_CPL != 2'h0
      |=> FAULT_GP && FAULT_ERR == 16'h0000 ##1 st_ff == gew_pkg::ST_IDLE;
  endproperty
  a_gp: assert property (p_gp) else $error("cpl fault missing");
  property p_ud;
    st_ff == gew_pkg::ST_IDLE && ENTRY_REQ && (!PROT_MODE || !VIRT_EN) |=> FAULT_UD && !FAULT_GP;
  endproperty
  a_ud: assert property (p_ud) else $error("opcode fault missing");
  property p_order;
    st_ff == gew_pkg::ST_LOAD && $past(st_ff) != gew_pkg::ST_LOAD |-> $past(st_ff) == gew_pkg::ST_SAVE;
  endproperty
  a_order: assert property (p_order) else $error("load before save");
  property p_inval;
    st_ff == gew_pkg::ST_CHECK && bad_state
      |=> st_ff == gew_pkg::ST_EXIT ##1 EXIT_CODE == `GEW_EXIT_INVALID && HOST_RESUME;
  endproperty
  a_inval: assert property (p_inval) else $error("invalid state not exited");
  property p_gif_set;
    $rose(IN_GUEST) |-> GLOBAL_IRQ_GATE_FLAG;
  endproperty
  a_gif_set: assert property (p_gif_set) else $error("gate not set on entry");
  property p_exit;
    st_ff == gew_pkg::ST_EXIT |=> !GLOBAL_IRQ_GATE_FLAG && INTERCEPT_VEC == 32'h0000_0000 && tsc_ff == 64'h0;
  endproperty
  a_exit: assert property (p_exit) else $error("exit cleanup missing");
  property p_tsc;
    TSC_RD |=> TSC_OUT_VLD && TSC_OUT == $past(TSC_VAL) + $past(tsc_ff);
  endproperty
  a_tsc: assert property (p_tsc) else $error("timestamp offset wrong");
  property p_cpl;
    $rose(IN_GUEST) && !cr0_ff[`GEW_CR0_PE] |-> GUEST_CPL == 2'h0;
  endproperty
  a_cpl: assert property (p_cpl) else $error("real mode cpl not 0");
  property p_ss;
    $rose(IN_GUEST) && long64 |-> SEG_VIEW.ss_present;
  endproperty
  a_ss: assert property (p_ss) else $error("64-bit stack not present");
  property p_resume;
    st_ff == gew_pkg::ST_GUEST && INTERCEPT_HIT |=> ##1 HOST_RESUME && !IN_GUEST;
  endproperty
  a_resume: assert property (p_resume) else $error("no host resume");
  c_entry: cover property ($rose(IN_GUEST));
  c_icpt: cover property (IN_GUEST && INTERCEPT_HIT);
  c_page_dir_pointer_entry: cover property (st_ff == gew_pkg::ST_PAGE_DIR_POINTER_ENTRY ##1 st_ff == gew_pkg::ST_EXIT);
  c_bad: cover property (st_ff == gew_pkg::ST_CHECK && bad_state);
endmodule

// file: tb/gew_mem_model.sv
/*
 System memory seen by the guest-entry sequencer: a word store that counts
 writes, reads and page-directory reads, and acknowledges after dly wait cycles.
 Assumes one request in flight, held until its acknowledge.
*/
`timescale 1ns/1ns
module gew_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire gew_pkg::gew_mem_req_s req_in,
  output logic ack,
  output logic [63:0] rdata
);
  logic [63:0] mem [logic [63:0]];
  logic [63:0] pd_base = 64'h3_0000;
  int dly = 0;
  int cnt = 0;
  int n_wr = 0;
  int n_rd = 0;
  int n_pd = 0;
  bit wr_after_rd = 0;
  // read data outside an acknowledge toggles, so a stale word never passes for a fresh one
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      rdata <= 64'h0;
      cnt = 0;
    end else if (ack || !req_in.req) begin
      ack <= 1'b0;
      rdata <= ~rdata;
    end else if (cnt < dly) begin
      cnt = cnt + 1;
      rdata <= ~rdata;
    end else begin
      cnt = 0;
      ack <= 1'b1;
      if (req_in.we) begin
        mem[req_in.addr] = req_in.wdata;
        n_wr++;
        if (n_rd != 0) wr_after_rd = 1;
      end else begin
        rdata <= mem.exists(req_in.addr) ? mem[req_in.addr] : 64'h0;
        n_rd++;
        if (req_in.addr >= pd_base && req_in.addr < pd_base + 64'h20) n_pd++;
      end
    end
  end
endmodule

// file: tb/gew_guest_entry_bench.sv
/*
 Self-checking bench of the guest-entry sequencer: register port, entry faults,
 host save, guest load, state checks, page-directory reads and exits.
 Assumes gew_mem_model as memory and a combinational host-item source.
*/
`timescale 1ns/1ns
`include "gew_defines.svh"
module gew_guest_entry_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ereq = 1'b0;
  logic [1:0] current_privilege_level = 2'h0;
  logic pmode = 1'b1;
  logic ven = 1'b1;
  logic [1:0] asz = 2'h1;
  logic [63:0] acc = 64'h0;
  logic ihit = 1'b0;
  logic [15:0] icode = 16'h0;
  logic trd = 1'b0;
  logic [63:0] tval = 64'h1_0000_0000;
  logic [31:0] rdata, ivec, atag, r;
  logic [3:0] hsel;
  logic [63:0] hval, mrd, gdata, tout, blk;
  gew_pkg::gew_mem_req_s mreq;
  gew_pkg::gew_seg_view_s seg;
  logic mack, gwe, fgp, fud, gpg, ing, global_irq_gate_flag, hres, tvld;
  logic [4:0] gidx;
  logic [15:0] ferr, xcode;
  logic [1:0] gcpl;
  int n_fail = 0;
  int cmp_count = 0;
  int n_gst, n_gp, n_ud, n_gpg, n_res;
  int bad_i [4] = '{1, 0, 18, 14};
  logic [63:0] bad_v [4] = '{64'h0, 64'h1234, 64'h0, 64'h2000_0001};
  assign hval = {60'hABC_0000_0000_0000, hsel};
  gew_guest_entry dut_u (
    .SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .ENTRY_REQ(ereq), .CUR_CPL(current_privilege_level), .PROT_MODE(pmode), .VIRT_EN(ven), .ADDR_SIZE(asz),
    .ACC_REG(acc), .HOST_SEL(hsel), .HOST_VAL(hval), .MEM_OUT(mreq), .MEM_ACK(mack),
    .MEM_RDATA(mrd), .GST_WE(gwe), .GST_IDX(gidx), .GST_DATA(gdata), .FAULT_GP(fgp),
    .FAULT_UD(fud), .FAULT_ERR(ferr), .GP_IN_GUEST(gpg), .IN_GUEST(ing), .GLOBAL_IRQ_GATE_FLAG(global_irq_gate_flag),
    .GUEST_CPL(gcpl), .SEG_VIEW(seg), .INTERCEPT_VEC(ivec), .ACTIVE_TAG(atag),
    .INTERCEPT_HIT(ihit), .INTERCEPT_CODE(icode), .HOST_RESUME(hres), .EXIT_CODE(xcode),
    .TSC_RD(trd), .TSC_VAL(tval), .TSC_OUT(tout), .TSC_OUT_VLD(tvld)
  );
  gew_mem_model mem_u (.clk(clk), .rst(rst), .req_in(mreq), .ack(mack), .rdata(mrd));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // pulses are counted one edge late, so callers wait two edges before reading counts
  always @(posedge clk) begin
    if (gwe === 1'b1) begin
      n_gst++;
      check("guest word", gdata, mem_u.mem[blk + {56'h0, gidx, 3'h0}]);
    end
    if (fgp === 1'b1) begin
      n_gp++;
      check("fault code", ferr, 0);
    end
    n_ud += int'(fud === 1'b1);
    n_gpg += int'(gpg === 1'b1);
    n_res += int'(hres === 1'b1);
  end
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic put(input int i, input logic [63:0] v);
    mem_u.mem[blk + 64'(i) * 8] = v;
  endtask
  task automatic fill(input logic [63:0] b);
    blk = b;
    for (int i = 0; i < 28; i++) put(i, {32'h0, 16'h5A5A, 16'(i)});
    put(0, 64'h1_0000_1234);
    put(1, 64'h5);
    put(2, 64'h100);
    put(3, 64'hC9B_0008);
    put(4, 64'hFFFF);
    put(6, 64'h10);
    put(7, 64'h2);
    put(9, 64'h493_0010);
    put(14, 64'h1);
    put(16, 64'h3_0000);
    put(17, 64'h0);
    put(18, 64'h1000);
    put(27, 64'h2);
  endtask
  task automatic enter(input logic [63:0] a, input logic [1:0] s);
    n_gst = 0;
    n_gp = 0;
    n_ud = 0;
    n_gpg = 0;
    n_res = 0;
    mem_u.n_wr = 0;
    mem_u.n_rd = 0;
    mem_u.n_pd = 0;
    mem_u.wr_after_rd = 0;
    @(posedge clk);
    acc <= a;
    asz <= s;
    ereq <= 1'b1;
    @(posedge clk);
    ereq <= 1'b0;
    for (int k = 0; k < 3000; k++) begin
      @(posedge clk);
      #1;
      // a fault pulse is gone before the first look, so its count ends the wait instead
      if (ing === 1'b1 || hres === 1'b1 || fgp === 1'b1 || fud === 1'b1 || n_ud != 0 || n_gp != 0) break;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic tsc(input logic [63:0] e);
    @(posedge clk);
    trd <= 1'b1;
    @(posedge clk);
    trd <= 1'b0;
    #1;
    check("tsc valid", tvld, 1);
    check("tsc", tout, e);
  endtask
  task automatic leave(input logic [15:0] c);
    n_res = 0;
    @(posedge clk);
    ihit <= 1'b1;
    icode <= c;
    @(posedge clk);
    ihit <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("resume", n_res, 1);
    check("exit code", xcode, c);
    check("gate after exit", global_irq_gate_flag, 0);
    check("guest after exit", ing, 0);
    check("vectors after exit", {ivec, atag}, 0);
    tsc(tval);
  endtask
  // the whole sequence needs under two thousand cycles; the limit of 60000 cycles leaves a wide margin
  initial begin
    #(60000 * 50);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rreg(`GEW_RA_TAGS, r);
    check("tag count", r, `GEW_TAG_COUNT);
    rreg(8'h20, r);
    check("unmapped", r, 0);
    wreg(`GEW_RA_HSAVE_LO, 32'h2_0FFF);
    wreg(`GEW_RA_HSAVE_HI, 32'h0);
    rreg(`GEW_RA_HSAVE_LO, r);
    check("save address", r, 32'h2_0000);
    @(posedge clk);
    #1;
    check("read data idle", rdata, 0);
    wreg(`GEW_RA_CTRL, 32'h1);
    rreg(`GEW_RA_STATUS, r);
    check("gate cleared", r[0], 0);
    wreg(`GEW_RA_CTRL, 32'h2);
    rreg(`GEW_RA_STATUS, r);
    check("gate set by software", r[0], 1);
    wreg(`GEW_RA_CTRL, 32'h1);
    rreg(`GEW_RA_STATUS, r);
    check("gate cleared again", r[0], 0);
    fill(64'h1_0000);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pmode <= i == 1 || i == 2;
      ven <= i != 1;
      current_privilege_level <= i >= 2 ? 2'h3 : 2'h0;
      enter(64'h1_0000, 2'h1);
      check("undef fault", n_ud, i != 2);
      check("prot fault", n_gp, i == 2);
      check("no save on fault", mem_u.n_wr, 0);
    end
    @(posedge clk);
    pmode <= 1'b1;
    current_privilege_level <= 2'h0;
    enter(64'hFFFF_FFFF_0001_0000, 2'h1);
    check("in guest", ing, 1);
    check("gate set", global_irq_gate_flag, 1);
    check("loaded words", n_gst, 28);
    check("guest level", gcpl, 2);
    check("segment view", seg, 8'hB5);
    check("vectors", {ivec, atag}, 64'h1234_0000_0005);
    check("host items", mem_u.n_wr, 14);
    check("save first", mem_u.wr_after_rd, 0);
    for (int i = 0; i < 14; i++) check("host word", mem_u.mem[64'h2_0000 + 64'(i) * 8], {60'hABC_0000_0000_0000, 4'(i)});
    tsc(tval + 64'h100);
    leave(16'h77);
    rreg(`GEW_RA_STATUS, r);
    check("status code", r[31:16], 16'h77);
    mem_u.dly = 3;
    fill(64'h1_0001_0000);
    put(7, 64'h2_0002);
    put(6, 64'h2_0000);
    enter(64'h1_0001_0000, 2'h2);
    check("v86 level", gcpl, 3);
    check("guest fault", n_gpg, 1);
    check("bad rip runs", ing, 1);
    leave(16'h78);
    mem_u.dly = 0;
    fill(64'h1000);
    put(14, 64'h0);
    put(9, 64'h10);
    enter(64'hFFFF_0003_1000, 2'h0);
    check("real level", gcpl, 0);
    check("null stack", seg, 8'hA0);
    leave(16'h79);
    fill(64'h1_0000);
    put(3, 64'hA9B_0008);
    put(9, 64'h10);
    put(14, 64'h8000_0001);
    put(17, 64'h20);
    put(18, 64'h1500);
    enter(64'h1_0000, 2'h1);
    check("long stack", seg, 8'h61);
    check("no table reads", mem_u.n_pd, 0);
    leave(16'h7A);
    for (int i = 0; i < 4; i++) begin
      fill(64'h1_0000);
      put(bad_i[i], bad_v[i]);
      enter(64'h1_0000, 2'h1);
      check("bad state exit", n_res, 1);
      check("bad state code", xcode, `GEW_EXIT_INVALID);
      check("bad state guest", ing, 0);
    end
    for (int i = 0; i < 3; i++) begin
      fill(64'h1_0000);
      put(0, i == 2 ? 64'h3_0000_1234 : 64'h1_0000_1234);
      put(14, 64'h8000_0001);
      put(17, 64'h20);
      for (int j = 0; j < 4; j++) mem_u.mem[64'h3_0000 + 64'(j) * 8] = (i != 0 && j == 3) ? 64'h3 : 64'h1;
      enter(64'h1_0000, 2'h1);
      check("table reads", mem_u.n_pd, i == 2 ? 0 : 4);
      check("table exit", n_res, i == 1);
      if (ing === 1'b1) leave(16'h7B);
    end
    end_of_test();
  end
endmodule
